// >>> pkg/cap_alarm_pkg.sv
// cap_alarm_pkg: constants shared by the alarm/output block and its miso shifter.
// assumes a 40 MHz core clock; all values are plain localparams.
package cap_alarm_pkg;
    // clock and timing
    localparam int  CORE_CLK_PERIOD_NS = 25;
    localparam int  UPDATE_PERIOD_NS   = 100000;  // free-running update interval
    localparam int  UPDATE_CYCLES      = UPDATE_PERIOD_NS / CORE_CLK_PERIOD_NS;
    localparam int  UPD_CNT_W          = 12;

    // data widths
    localparam int  MEAS_W             = 14;
    localparam int  SPI_WORD_W         = 16;
    localparam int  I2C_ADDR_W         = 7;

    // output selection codes
    localparam logic [1:0] OUT_SEL_I2C = 2'h0;
    localparam logic [1:0] OUT_SEL_SPI = 2'h1;
    localparam logic [1:0] OUT_SEL_PDM = 2'h2;

    // resolution codes
    localparam logic [1:0] RES_8       = 2'h0;
    localparam logic [1:0] RES_10      = 2'h1;
    localparam logic [1:0] RES_12      = 2'h2;
    localparam logic [1:0] RES_14      = 2'h3;

    // kept-bit masks for each resolution on a 14-bit result
    localparam logic [13:0] MASK_8     = 14'h3FC0;
    localparam logic [13:0] MASK_10    = 14'h3FF0;
    localparam logic [13:0] MASK_12    = 14'h3FFC;
    localparam logic [13:0] MASK_14    = 14'h3FFF;

    // reset values
    localparam logic [13:0] MEAS_RST   = 14'h0000;
endpackage

// >>> hw/miso_shifter.sv
// miso_shifter: serial read-out shift register on the spi clock.
// assumes i_word is held stable by the core while a frame is active.
`timescale 1ns/1ps
`default_nettype none
module miso_shifter
    import cap_alarm_pkg::*;
(
    // link pins
    input  wire logic                  i_sclk,
    input  wire logic                  i_ss_n,
    // configuration and data
    input  wire logic                  i_phase,
    input  wire logic [SPI_WORD_W-1:0] i_word,
    // serial out
    output logic                       o_miso
);
    typedef struct packed {
        logic [4:0]            cnt;
        logic [SPI_WORD_W-1:0] sh;
    } shift_t;

    shift_t shift_reg;
    shift_t shift_next;
    logic   fall_bit_reg;

    // frame bit counter and shifter; load on the first rising edge
    always_comb begin
        shift_next = shift_reg;
        if (shift_reg.cnt == 5'h00) begin
            shift_next.sh = i_word;
        end else begin
            shift_next.sh = {shift_reg.sh[SPI_WORD_W-2:0], 1'b0};
        end
        if (shift_reg.cnt != 5'h1F) begin
            shift_next.cnt = shift_reg.cnt + 5'h01;
        end
    end

    // the frame select itself ends the frame; the clock may stop any time
    always_ff @(posedge i_sclk or posedge i_ss_n) begin
        if (i_ss_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // phase 0: next bit changes on the falling edge, ready for the rising sample
    always_ff @(negedge i_sclk or posedge i_ss_n) begin
        if (i_ss_n) begin
            fall_bit_reg <= 1'b0;
        end else begin
            fall_bit_reg <= shift_reg.sh[SPI_WORD_W-2];
        end
    end

    // phase 1 changes on rising so the master samples on falling
    always_comb begin
        if (i_phase) begin
            o_miso = shift_reg.sh[SPI_WORD_W-1];
        end else if (shift_reg.cnt == 5'h00) begin
            o_miso = i_word[SPI_WORD_W-1];
        end else begin
            o_miso = fall_bit_reg;
        end
    end
endmodule
`default_nettype wire

// >>> hw/cap_alarm_out.sv
// cap_alarm_out: alarm outputs, output selection, update control and read-out
// of a capacitive sensor conditioner. assumes corrected measurements arrive
// on the core clock; spi clock and select are pins from the host.
//
// Contract
// - the upper alarm goes active above its high trip and the lower alarm below its low trip.
// - each alarm decides with its own programmable trip point and hysteresis value.
// - with i2c or spi output both alarms work; with pulse output the lower alarm is given up.
// - in sleep operation a measurement starts only on a serial command, else it free-runs.
// - polarity 0 drives the pin high when active and open-drain 0 gives push-pull drive.
// - with spi phase 1 miso changes so that the master samples it on the falling sclk edge.
// - with the address lock cleared every i2c slave address is acknowledged.
// - the ready output can be open drain so several ready lines can be wired together.
// - differential mode measures a differential input and forces reference and offset to zero.
// - capacitance and temperature resolutions are chosen separately among 8, 10, 12, 14 bits.
// - output selection code binary 10 selects pulse-density output.
`timescale 1ns/1ps
`default_nettype none
module cap_alarm_out
    import cap_alarm_pkg::*;
#(
    parameter int UPDATE_CNT = UPDATE_CYCLES
)
(
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_nrst,
    // measurement path
    input  wire logic                  i_meas_valid,
    input  wire logic [MEAS_W-1:0]     i_cap_value,
    input  wire logic [MEAS_W-1:0]     i_temp_value,
    input  wire logic                  i_meas_cmd,
    // configuration
    input  wire logic [1:0]            i_out_sel,
    input  wire logic                  i_update_mode,
    input  wire logic [1:0]            i_cap_res,
    input  wire logic [1:0]            i_temp_res,
    input  wire logic                  i_diff_mode,
    input  wire logic                  i_ref_cap_en,
    input  wire logic                  i_offset_cap_en,
    // alarm setup
    input  wire logic [MEAS_W-1:0]     i_alarm_hi_trip,
    input  wire logic [MEAS_W-1:0]     i_alarm_hi_hyst,
    input  wire logic                  i_alarm_hi_pol,
    input  wire logic                  i_alarm_hi_od,
    input  wire logic [MEAS_W-1:0]     i_alarm_lo_trip,
    input  wire logic [MEAS_W-1:0]     i_alarm_lo_hyst,
    input  wire logic                  i_alarm_lo_pol,
    input  wire logic                  i_alarm_lo_od,
    // pulse-density clip limits
    input  wire logic [MEAS_W-1:0]     i_pulse_output_upper_clip,
    input  wire logic [MEAS_W-1:0]     i_pulse_output_lower_clip,
    // i2c address check
    input  wire logic [I2C_ADDR_W-1:0] i_i2c_addr_rx,
    input  wire logic                  i_i2c_addr_valid,
    input  wire logic [I2C_ADDR_W-1:0] i_i2c_addr_prog,
    input  wire logic                  i_i2c_addr_lock,
    // ready pin
    input  wire logic                  i_ready_od,
    input  wire logic                  i_result_read,
    // spi link
    input  wire logic                  i_spi_sclk,
    input  wire logic                  i_spi_ss_n,
    input  wire logic                  i_spi_phase,
    output logic                       o_spi_miso,
    // alarm pins
    output logic                       o_alarm_hi_out,
    output logic                       o_alarm_hi_oe,
    output logic                       o_alarm_lo_out,
    output logic                       o_alarm_lo_oe,
    // ready pin
    output logic                       o_ready_out,
    output logic                       o_ready_oe,
    // results and front-end control
    output logic [MEAS_W-1:0]          o_cap_result,
    output logic [MEAS_W-1:0]          o_temp_result,
    output logic                       o_meas_start,
    output logic                       o_i2c_addr_ack,
    output logic                       o_pdm,
    output logic                       o_diff_sel,
    output logic                       o_ref_cap_sel,
    output logic                       o_offset_cap_sel
);
    typedef struct packed {
        logic [1:0]            ss_sync;
        logic                  hi_act;
        logic                  lo_act;
        logic                  hi_out;
        logic                  hi_oe;
        logic                  lo_out;
        logic                  lo_oe;
        logic                  ready;
        logic                  rdy_out;
        logic                  rdy_oe;
        logic [MEAS_W-1:0]     cap;
        logic [MEAS_W-1:0]     temp;
        logic [SPI_WORD_W-1:0] tx_word;
        logic                  tx_pend;
        logic [UPD_CNT_W-1:0]  upd_cnt;
        logic                  start;
        logic                  ack;
        logic [MEAS_W:0]       pdm_acc;
        logic                  pdm;
        logic                  diff;
        logic                  ref_sel;
        logic                  off_sel;
    } state_t;

    localparam logic [UPD_CNT_W-1:0] UPD_LAST = UPD_CNT_W'(UPDATE_CNT - 1);

    state_t state_reg;
    state_t state_next;

    // result masking per selected resolution
    function automatic logic [MEAS_W-1:0] res_mask(input logic [1:0] code);
        logic [MEAS_W-1:0] m;
        case (code)
            RES_8:   m = MASK_8;
            RES_10:  m = MASK_10;
            RES_12:  m = MASK_12;
            default: m = MASK_14;
        endcase
        return m;
    endfunction

    // pin drive: open drain only pulls low, push-pull always drives
    function automatic logic [1:0] pin_drive(input logic level, input logic od);
        logic [1:0] d;
        if (od) begin
            d = {1'b0, ~level};
        end else begin
            d = {level, 1'b1};
        end
        return d;
    endfunction

    logic              pdm_sel;
    logic [MEAS_W:0]   hi_clear_lvl;
    logic [MEAS_W:0]   lo_clear_lvl;
    logic [MEAS_W-1:0] pdm_in;
    logic              hi_lvl;
    logic              lo_lvl;
    logic              frame_idle;

    // output selection decode
    assign pdm_sel      = (i_out_sel == OUT_SEL_PDM);
    // widened; a borrow in the high clear level means that alarm never clears
    assign hi_clear_lvl = {1'b0, i_alarm_hi_trip} - {1'b0, i_alarm_hi_hyst};
    assign lo_clear_lvl = {1'b0, i_alarm_lo_trip} + {1'b0, i_alarm_lo_hyst};
    assign frame_idle   = state_reg.ss_sync[1];

    // clip the pulse-density input to the programmed window
    always_comb begin
        if (state_reg.cap > i_pulse_output_upper_clip) begin
            pdm_in = i_pulse_output_upper_clip;
        end else if (state_reg.cap < i_pulse_output_lower_clip) begin
            pdm_in = i_pulse_output_lower_clip;
        end else begin
            pdm_in = state_reg.cap;
        end
    end

    // next-state logic
    always_comb begin
        state_next         = state_reg;
        state_next.ss_sync = {state_reg.ss_sync[0], i_spi_ss_n};

        // measurement trigger: free-running count or serial command only
        state_next.start = 1'b0;
        if (i_update_mode) begin
            if (state_reg.upd_cnt >= UPD_LAST) begin
                state_next.upd_cnt = '0;
                state_next.start   = 1'b1;
            end else begin
                state_next.upd_cnt = state_reg.upd_cnt + 1'b1;
            end
        end else begin
            state_next.upd_cnt = '0;
            state_next.start   = i_meas_cmd;
        end

        // results at separately chosen resolutions
        if (i_meas_valid) begin
            state_next.cap  = i_cap_value & res_mask(i_cap_res);
            state_next.temp = i_temp_value & res_mask(i_temp_res);
            state_next.tx_pend = 1'b1;
            // high alarm: set above trip, clear at trip less hysteresis
            if (i_cap_value > i_alarm_hi_trip) begin
                state_next.hi_act = 1'b1;
            end else if (!hi_clear_lvl[MEAS_W] && ({1'b0, i_cap_value} <= hi_clear_lvl)) begin
                state_next.hi_act = 1'b0;
            end
            // low alarm: set below trip, clear at trip plus hysteresis
            if (i_cap_value < i_alarm_lo_trip) begin
                state_next.lo_act = 1'b1;
            end else if ({1'b0, i_cap_value} >= lo_clear_lvl) begin
                state_next.lo_act = 1'b0;
            end
        end

        // spi word only changes between frames, so the link sees it stable
        if (state_next.tx_pend && frame_idle) begin
            state_next.tx_word = {2'h0, state_next.cap};
            state_next.tx_pend = 1'b0;
        end

        // ready flag: a new result wins over a read in the same cycle
        if (i_meas_valid) begin
            state_next.ready = 1'b1;
        end else if (i_result_read) begin
            state_next.ready = 1'b0;
        end
        {state_next.rdy_out, state_next.rdy_oe} = pin_drive(state_reg.ready, i_ready_od);

        // alarm pins: polarity 0 is active high, od 0 is push-pull
        hi_lvl = state_reg.hi_act ^ i_alarm_hi_pol;
        lo_lvl = state_reg.lo_act ^ i_alarm_lo_pol;
        {state_next.hi_out, state_next.hi_oe} = pin_drive(hi_lvl, i_alarm_hi_od);
        if (pdm_sel) begin
            // low alarm pin is given up to the pulse stream
            state_next.lo_out = 1'b0;
            state_next.lo_oe  = 1'b0;
        end else begin
            {state_next.lo_out, state_next.lo_oe} = pin_drive(lo_lvl, i_alarm_lo_od);
        end

        // first-order pulse-density modulator; idle low when not selected
        if (pdm_sel) begin
            state_next.pdm_acc = {1'b0, state_reg.pdm_acc[MEAS_W-1:0]} + {1'b0, pdm_in};
            state_next.pdm     = state_next.pdm_acc[MEAS_W];
        end else begin
            state_next.pdm_acc = '0;
            state_next.pdm     = 1'b0;
        end

        // address check: lock cleared answers any address
        state_next.ack = i_i2c_addr_valid && (!i_i2c_addr_lock || (i_i2c_addr_rx == i_i2c_addr_prog));

        // front-end select: differential forces reference and offset off
        state_next.diff    = i_diff_mode;
        state_next.ref_sel = i_ref_cap_en && !i_diff_mode;
        state_next.off_sel = i_offset_cap_en && !i_diff_mode;
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            state_reg         <= '0;
            state_reg.ss_sync <= 2'h3;
            state_reg.cap     <= MEAS_RST;
            state_reg.temp    <= MEAS_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // link-side shifter on the spi clock
    miso_shifter u_miso (
        .i_sclk  (i_spi_sclk),
        .i_ss_n  (i_spi_ss_n),
        .i_phase (i_spi_phase),
        .i_word  (state_reg.tx_word),
        .o_miso  (o_spi_miso)
    );

    // outputs straight from the state register
    assign o_alarm_hi_out   = state_reg.hi_out;
    assign o_alarm_hi_oe    = state_reg.hi_oe;
    assign o_alarm_lo_out   = state_reg.lo_out;
    assign o_alarm_lo_oe    = state_reg.lo_oe;
    assign o_ready_out      = state_reg.rdy_out;
    assign o_ready_oe       = state_reg.rdy_oe;
    assign o_cap_result     = state_reg.cap;
    assign o_temp_result    = state_reg.temp;
    assign o_meas_start     = state_reg.start;
    assign o_i2c_addr_ack   = state_reg.ack;
    assign o_pdm            = state_reg.pdm;
    assign o_diff_sel       = state_reg.diff;
    assign o_ref_cap_sel    = state_reg.ref_sel;
    assign o_offset_cap_sel = state_reg.off_sel;
endmodule
`default_nettype wire

// >>> sim/cap_alarm_out_checker.sv
// cap_alarm_out_checker: port assertions for the alarm and output block.
// assumes it is bound into cap_alarm_out and sees only core-clock ports.
`timescale 1ns/1ps
`default_nettype none
module cap_alarm_out_checker
    import cap_alarm_pkg::*;
#(
    parameter int UPDATE_CNT = UPDATE_CYCLES
)
(
    // clock, reset and measurement
    input wire logic                  i_core_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_meas_valid,
    input wire logic [MEAS_W-1:0]     i_cap_value,
    input wire logic                  i_meas_cmd,
    input wire logic [1:0]            i_out_sel,
    input wire logic                  i_update_mode,
    // alarm setup
    input wire logic [MEAS_W-1:0]     i_alarm_hi_trip,
    input wire logic                  i_alarm_hi_pol,
    input wire logic                  i_alarm_hi_od,
    input wire logic [MEAS_W-1:0]     i_alarm_lo_trip,
    input wire logic                  i_alarm_lo_pol,
    input wire logic                  i_alarm_lo_od,
    // address check
    input wire logic [I2C_ADDR_W-1:0] i_i2c_addr_rx,
    input wire logic                  i_i2c_addr_valid,
    input wire logic [I2C_ADDR_W-1:0] i_i2c_addr_prog,
    input wire logic                  i_i2c_addr_lock,
    // watched outputs
    input wire logic                  o_alarm_hi_out,
    input wire logic                  o_alarm_hi_oe,
    input wire logic                  o_alarm_lo_out,
    input wire logic                  o_alarm_lo_oe,
    input wire logic                  o_meas_start,
    input wire logic                  o_i2c_addr_ack
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    // active-high push-pull setup; pin levels are only predictable with it
    sequence s_hi_pp;
        !i_alarm_hi_pol && !i_alarm_hi_od;
    endsequence
    sequence s_lo_pp;
        !i_alarm_lo_pol && !i_alarm_lo_od && (i_out_sel != OUT_SEL_PDM);
    endsequence
    // a sample past the trip point taken under that setup
    sequence s_hi_over;
        i_meas_valid && (i_cap_value > i_alarm_hi_trip) ##0 s_hi_pp;
    endsequence
    sequence s_lo_under;
        i_meas_valid && (i_cap_value < i_alarm_lo_trip) ##0 s_lo_pp;
    endsequence

    a_hi_alarm_set: assert property (
        s_hi_over ##1 s_hi_pp |=> o_alarm_hi_out && o_alarm_hi_oe)
        else $error("upper alarm pin not high after trip");
    a_lo_alarm_set: assert property (
        s_lo_under ##1 s_lo_pp |=> o_alarm_lo_out && o_alarm_lo_oe)
        else $error("lower alarm pin not high after trip");
    a_pulse_lo_free: assert property (
        (i_out_sel == OUT_SEL_PDM)[*2] |-> !o_alarm_lo_oe && !o_alarm_lo_out)
        else $error("lower alarm pin driven in pulse mode");
    a_hi_push_pull: assert property (
        $past(i_nrst) && !i_alarm_hi_od && !$past(i_alarm_hi_od) |-> o_alarm_hi_oe)
        else $error("push-pull alarm pin not enabled");
    a_addr_open: assert property (
        i_i2c_addr_valid && !i_i2c_addr_lock |=> o_i2c_addr_ack)
        else $error("address not acknowledged with lock cleared");
    a_addr_locked: assert property (
        i_i2c_addr_valid && i_i2c_addr_lock && (i_i2c_addr_rx != i_i2c_addr_prog)
        |=> !o_i2c_addr_ack)
        else $error("foreign address acknowledged under lock");
    a_sleep_cmd: assert property (
        !i_update_mode && i_meas_cmd |=> o_meas_start)
        else $error("sleep command did not start a measurement");
    a_sleep_quiet: assert property (
        !i_update_mode && !i_meas_cmd |=> !o_meas_start)
        else $error("measurement started in sleep without command");
endmodule

bind cap_alarm_out cap_alarm_out_checker #(.UPDATE_CNT(UPDATE_CNT)) u_checker (
    .i_core_clk, .i_nrst, .i_meas_valid, .i_cap_value, .i_meas_cmd, .i_out_sel,
    .i_update_mode, .i_alarm_hi_trip, .i_alarm_hi_pol, .i_alarm_hi_od, .i_alarm_lo_trip,
    .i_alarm_lo_pol, .i_alarm_lo_od, .i_i2c_addr_rx, .i_i2c_addr_valid, .i_i2c_addr_prog,
    .i_i2c_addr_lock, .o_alarm_hi_out, .o_alarm_hi_oe, .o_alarm_lo_out, .o_alarm_lo_oe,
    .o_meas_start, .o_i2c_addr_ack);
`default_nettype wire

// >>> sim/spi_host_model.sv
// spi_host_model: host side of the serial read-out, one frame per start.
// assumes sclk idles low and stands still between frames; 80 ns bit time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
    import cap_alarm_pkg::*;
(
    // control from the bench
    input  wire logic                  i_start,
    input  wire logic                  i_phase,
    // link pins
    input  wire logic                  i_miso,
    output logic                       o_sclk,
    output logic                       o_ss_n,
    // result
    output logic [SPI_WORD_W-1:0]      o_word,
    output logic                       o_busy
);
    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
        o_word = '0;
        o_busy = 1'b0;
    end
    // select gap of 150 ns covers the core-side select synchroniser
    always @(posedge i_start) begin
        o_busy = 1'b1;
        #7 o_ss_n = 1'b0;
        #150;
        for (int k = 0; k < SPI_WORD_W; k++) begin
            #40 if (!i_phase) o_word = {o_word[SPI_WORD_W-2:0], i_miso};
            o_sclk = 1'b1;
            #40 if (i_phase) o_word = {o_word[SPI_WORD_W-2:0], i_miso};
            o_sclk = 1'b0;
        end
        #40 o_ss_n = 1'b1;
        #40 o_busy = 1'b0;
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// testbench: directed checks of the alarm and output block.
// assumes the checker is bound by its own file and the spi host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cap_alarm_pkg::*;
    localparam int UPD = 8;
    logic i_core_clk, i_nrst, i_meas_valid, i_meas_cmd, i_update_mode, i_diff_mode;
    logic i_ref_cap_en, i_offset_cap_en, i_alarm_hi_pol, i_alarm_hi_od, i_alarm_lo_pol;
    logic i_alarm_lo_od, i_i2c_addr_valid, i_i2c_addr_lock, i_ready_od, i_result_read;
    logic i_spi_sclk, i_spi_ss_n, i_spi_phase, o_spi_miso, o_alarm_hi_out, o_alarm_hi_oe;
    logic o_alarm_lo_out, o_alarm_lo_oe, o_ready_out, o_ready_oe, o_meas_start, o_pdm;
    logic o_i2c_addr_ack, o_diff_sel, o_ref_cap_sel, o_offset_cap_sel, spi_start, spi_busy;
    logic [1:0] i_out_sel, i_cap_res, i_temp_res;
    logic [MEAS_W-1:0] i_cap_value, i_temp_value, i_alarm_hi_trip, i_alarm_hi_hyst;
    logic [MEAS_W-1:0] i_alarm_lo_trip, i_alarm_lo_hyst, o_cap_result, o_temp_result;
    logic [MEAS_W-1:0] i_pulse_output_upper_clip, i_pulse_output_lower_clip;
    logic [I2C_ADDR_W-1:0] i_i2c_addr_rx, i_i2c_addr_prog;
    logic [SPI_WORD_W-1:0] spi_word;
    int n_mismatch = 0;
    int compares = 0;

    cap_alarm_out #(.UPDATE_CNT(UPD)) u_dut (.*);
    spi_host_model u_host (.i_start(spi_start), .i_phase(i_spi_phase), .i_miso(o_spi_miso),
        .o_sclk(i_spi_sclk), .o_ss_n(i_spi_ss_n), .o_word(spi_word), .o_busy(spi_busy));

    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // one sample; returns once the alarm pins have followed it
    task automatic meas(input logic [MEAS_W-1:0] v);
        i_cap_value = v;
        i_meas_valid = 1'b1;
        tick(1);
        i_meas_valid = 1'b0;
        tick(2);
    endtask
    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // trip, hold inside the hysteresis band, clear at its edge
    task automatic t_alarm;
        logic [MEAS_W-1:0] v [7] = '{14'h1000, 14'h1001, 14'h0F01, 14'h0F00,
                                     14'h07FF, 14'h087F, 14'h0880};
        logic [6:0] hi = 7'b0000110;
        logic [6:0] lo = 7'b0110000;
        for (int k = 0; k < 7; k++) begin
            meas(v[k]);
            chk("hi_pins", {o_alarm_hi_out, o_alarm_hi_oe}, {hi[k], 1'b1});
            chk("lo_pins", {o_alarm_lo_out, o_alarm_lo_oe}, {lo[k], 1'b1});
        end
        i_alarm_hi_pol = 1'b1;
        i_alarm_hi_od = 1'b1;
        meas(14'h1001);
        chk("hi_od_active", {o_alarm_hi_out, o_alarm_hi_oe}, 2'b01);
        meas(14'h0A00);
        chk("hi_od_idle", {o_alarm_hi_out, o_alarm_hi_oe}, 2'b00);
        i_alarm_hi_pol = 1'b0;
        i_alarm_hi_od = 1'b0;
    endtask
    // pulse output gives up the lower alarm but keeps the upper one
    task automatic t_pdm;
        logic seen;
        i_update_mode = 1'b1;
        i_out_sel = OUT_SEL_PDM;
        meas(14'h07FF);
        chk("lo_pins_pdm", {o_alarm_lo_out, o_alarm_lo_oe}, 2'b00);
        meas(14'h2000);
        chk("hi_pins_pdm", {o_alarm_hi_out, o_alarm_hi_oe}, 2'b11);
        seen = 1'b0;
        repeat (64) begin tick(1); seen = seen | o_pdm; end
        chk("pdm_stream", seen, 1'b1);
        i_out_sel = OUT_SEL_SPI;
        tick(2);
        seen = 1'b0;
        repeat (32) begin tick(1); seen = seen | o_pdm; end
        chk("pdm_quiet", seen, 1'b0);
        chk("lo_pins_spi", {o_alarm_lo_out, o_alarm_lo_oe}, 2'b01);
        meas(14'h0900);
    endtask
    // sleep starts only on command; update free-runs and ignores commands
    task automatic t_trig;
        int n = 0;
        i_update_mode = 1'b0;
        tick(2);
        repeat (20) begin tick(1); n += o_meas_start; end
        chk("sleep_idle", 16'(n), 16'h0000);
        i_meas_cmd = 1'b1;
        tick(1);
        chk("sleep_start", o_meas_start, 1'b1);
        i_update_mode = 1'b1;
        tick(2);
        n = 0;
        repeat (3 * UPD) begin tick(1); n += o_meas_start; end
        chk("update_starts", 16'(n), 16'h0003);
        i_meas_cmd = 1'b0;
    endtask
    // open, locked-foreign and locked-own address
    task automatic t_addr;
        i_i2c_addr_prog = 7'h28;
        for (int k = 0; k < 3; k++) begin
            i_i2c_addr_lock = k[0] | k[1];
            i_i2c_addr_rx = (k == 2) ? 7'h28 : 7'h55;
            i_i2c_addr_valid = 1'b1;
            tick(1);
            i_i2c_addr_valid = 1'b0;
            chk("addr_ack", o_i2c_addr_ack, k != 1);
            tick(1);
            chk("addr_ack_end", o_i2c_addr_ack, 1'b0);
        end
    endtask
    // ready pin open drain: released when high, pulled when low
    task automatic t_ready;
        i_ready_od = 1'b1;
        i_result_read = 1'b1;
        tick(1);
        i_result_read = 1'b0;
        tick(1);
        chk("ready_od_low", {o_ready_out, o_ready_oe}, 2'b01);
        meas(14'h0900);
        chk("ready_od_high", {o_ready_out, o_ready_oe}, 2'b00);
        i_ready_od = 1'b0;
        tick(1);
        chk("ready_pp", {o_ready_out, o_ready_oe}, 2'b11);
    endtask
    // separate resolutions for both results, then the differential selects
    task automatic t_res;
        logic [13:0] m [4] = '{MASK_8, MASK_10, MASK_12, MASK_14};
        i_temp_value = 14'h3FFF;
        for (int k = 0; k < 4; k++) begin
            i_cap_res = 2'(k);
            i_temp_res = 2'(3 - k);
            meas(14'h3FFF);
            chk("cap_res", o_cap_result, m[k]);
            chk("temp_res", o_temp_result, m[3 - k]);
        end
        i_cap_res = RES_14;
        for (int k = 0; k < 2; k++) begin
            i_diff_mode = k[0];
            tick(1);
            chk("selects", {o_diff_sel, o_ref_cap_sel, o_offset_cap_sel}, k ? 3'h4 : 3'h3);
        end
    endtask
    // read the result in both clock phases
    task automatic t_spi;
        int n;
        meas(14'h2A5C);
        tick(3);
        for (int k = 0; k < 2; k++) begin
            i_spi_phase = k[0];
            spi_start = 1'b1;
            tick(1);
            spi_start = 1'b0;
            n = 0;
            while (spi_busy && n < 200) begin tick(1); n++; end
            if (n == 200) begin n_mismatch++; end_sim; end
            chk("spi_word", spi_word, {2'b00, 14'h2A5C});
            tick(4);
        end
    endtask

    initial begin
        repeat (50000) @(posedge i_core_clk);
        n_mismatch++;
        end_sim;
    end
    initial begin
        {i_nrst, i_meas_valid, i_meas_cmd, i_diff_mode, i_alarm_hi_pol, i_alarm_hi_od,
         i_alarm_lo_pol, i_alarm_lo_od, i_i2c_addr_valid, i_i2c_addr_lock, i_ready_od,
         i_result_read, i_spi_phase, spi_start, i_update_mode} = '0;
        {i_cap_value, i_temp_value, i_i2c_addr_rx, i_i2c_addr_prog, i_out_sel} = '0;
        {i_cap_res, i_temp_res, i_ref_cap_en, i_offset_cap_en} = {RES_14, RES_14, 2'b11};
        {i_alarm_hi_trip, i_alarm_hi_hyst} = {14'h1000, 14'h0100};
        {i_alarm_lo_trip, i_alarm_lo_hyst} = {14'h0800, 14'h0080};
        {i_pulse_output_upper_clip, i_pulse_output_lower_clip} = {14'h3999, 14'h0666};
        tick(12);
        i_nrst = 1'b1;
        tick(1);
        chk("hi_idle", {o_alarm_hi_out, o_alarm_hi_oe}, 2'b01);
        t_alarm();
        t_pdm();
        t_trig();
        t_addr();
        t_ready();
        t_res();
        t_spi();
        end_sim();
    end
endmodule
`default_nettype wire
